// ==== pkg/amc_consts.svh ====
// Register addresses, field positions, reset values and timing figures of the measure control
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH

// Register addresses on the core's register port
`define AMC_ADDR_TEMP_RESULT   8'hD7
`define AMC_ADDR_START         8'hD8
`define AMC_ADDR_BATT_RESULT   8'hDF
`define AMC_ADDR_PM_IRQ_EN     8'hEC
`define AMC_ADDR_SUPPLY_RESULT 8'hEF
`define AMC_ADDR_DELTA         8'hF3
`define AMC_ADDR_PM_FLAGS      8'hF8
`define AMC_ADDR_INTERVAL      8'hF9
`define AMC_ADDR_THRESHOLD     8'hFA

// Field positions
`define AMC_START_BATT_BIT     0
`define AMC_START_TEMP_BIT     1
`define AMC_LOW_CELL_BIT       2
`define AMC_TEMP_PERIOD_LSB    0
`define AMC_CELL_PERIOD_LSB    2
`define AMC_PERIOD_W           2
`define AMC_DELTA_LSB          3
`define AMC_DELTA_W            3

// Reset values
`define AMC_RESET_BYTE         8'h00
`define AMC_RESET_PERIOD       2'h0
`define AMC_RESET_DELTA        3'h0

// Delta codes with special meaning
`define AMC_DELTA_NONE         3'h0
`define AMC_DELTA_EVERY        3'h7

// Period code that means no background conversion
`define AMC_PERIOD_OFF         2'h0

// Timing: clock rate in Hz, intervals in minutes, one minute in seconds
`define AMC_CLK_HZ             200000000
`define AMC_SEC_PER_MIN        60
`define AMC_TEMP_P1_MIN        8
`define AMC_TEMP_P2_MIN        2
`define AMC_TEMP_P3_MIN        1
`define AMC_CELL_P1_MIN        16
`define AMC_CELL_P2_MIN        4
`define AMC_CELL_P3_MIN        1

// Request slots at the arbiter, in priority order
`define AMC_SLOT_TEMP_SINGLE   2'h0
`define AMC_SLOT_CELL_SINGLE   2'h1
`define AMC_SLOT_TEMP_BG       2'h2
`define AMC_SLOT_CELL_BG       2'h3
`define AMC_SLOTS              4

`endif

// ==== pkg/amc_pkg.sv ====
// Types shared by the measure control modules
package amc_pkg;

  // Power mode of the device
  typedef enum logic [1:0] {
    AMC_MAINS_ACTIVE_MODE,
    AMC_CELL_ACTIVE_MODE,
    AMC_CORE_OFF_MODE,
    AMC_MODE_SPARE
  } amc_mode_t;

  // Converter channel
  typedef enum logic {
    AMC_CHAN_TEMP,
    AMC_CHAN_CELL
  } amc_chan_t;

endpackage : amc_pkg

// ==== pkg/amc_conv_if.sv ====
// Request and completion carrier between the control core and the arbiter
`timescale 1ns/100ps
interface amc_conv_if;
  logic [3:0] pend;       // Pending request per slot
  logic [3:0] accept;     // Slot taken by converter, one-cycle pulse
  logic       done;       // Conversion finished, one-cycle pulse
  logic [1:0] done_slot;  // Slot that finished
  logic [7:0] done_data;  // Converted value

  modport ctrl (output pend, input accept, input done, input done_slot, input done_data);
  modport arb  (input pend, output accept, output done, output done_slot, output done_data);
endinterface : amc_conv_if

// ==== logic/amc_interval_timer.sv ====
// Background interval timer: one due pulse per programmed interval
`timescale 1ns/100ps
`include "amc_consts.svh"
module amc_interval_timer #(
  parameter int unsigned SEC_CYCLES = `AMC_CLK_HZ,
  parameter int unsigned P1_MIN     = 1,
  parameter int unsigned P2_MIN     = 1,
  parameter int unsigned P3_MIN     = 1
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] period_i,
  input  wire logic       run_i,
  output logic            due_o
);
  import amc_pkg::*;

  localparam int unsigned P1_S = P1_MIN * `AMC_SEC_PER_MIN;
  localparam int unsigned P2_S = P2_MIN * `AMC_SEC_PER_MIN;
  localparam int unsigned P3_S = P3_MIN * `AMC_SEC_PER_MIN;

  logic [31:0] pre_reg;
  logic [15:0] sec_reg;
  logic [1:0]  period_reg;
  logic [15:0] limit;
  logic        active;
  logic        sec_tick;
  logic        restart;

  // Interval length in seconds, less one, for the code in force
  assign limit    = (period_i == 2'h1) ? 16'(P1_S - 1) :
                    (period_i == 2'h2) ? 16'(P2_S - 1) : 16'(P3_S - 1);
  assign active   = run_i && (period_i != `AMC_PERIOD_OFF);
  assign restart  = !active || (period_i != period_reg);
  assign sec_tick = (pre_reg == 32'(SEC_CYCLES - 1));

  // Prescaler to seconds; a new code restarts the interval from zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_reg    <= 32'h0;
      sec_reg    <= 16'h0;
      period_reg <= `AMC_RESET_PERIOD;
      due_o      <= 1'b0;
    end else begin
      period_reg <= period_i;
      due_o      <= 1'b0;
      if (restart) begin
        pre_reg <= 32'h0;
        sec_reg <= 16'h0;
      end else if (sec_tick) begin
        pre_reg <= 32'h0;
        if (sec_reg >= limit) begin
          sec_reg <= 16'h0;
          due_o   <= 1'b1;
        end else begin
          sec_reg <= sec_reg + 16'h1;
        end
      end else begin
        pre_reg <= pre_reg + 32'h1;
      end
    end
  end
endmodule : amc_interval_timer

// ==== logic/amc_conv_arbiter.sv ====
// Converter arbiter: serves one pending slot at a time in fixed priority
`timescale 1ns/100ps
`include "amc_consts.svh"
module amc_conv_arbiter (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  amc_conv_if.arb           cv,
  output logic              conv_req_o,
  output amc_pkg::amc_chan_t conv_chan_o,
  input  wire logic         conv_ack_i,
  input  wire logic         conv_done_i,
  input  wire logic [7:0]   conv_data_i
);
  import amc_pkg::*;

  typedef enum logic [1:0] {ARB_IDLE, ARB_REQ, ARB_BUSY} amc_arb_state_t;

  amc_arb_state_t state_reg;
  logic [1:0]     slot_reg;
  logic [1:0]     pick;
  logic [3:0]     slot_hit;

  // Lowest slot number wins, so single starts beat background ticks
  assign pick = cv.pend[0] ? `AMC_SLOT_TEMP_SINGLE :
                cv.pend[1] ? `AMC_SLOT_CELL_SINGLE :
                cv.pend[2] ? `AMC_SLOT_TEMP_BG : `AMC_SLOT_CELL_BG;

  // Accept pulse per slot while the converter takes the request
  for (genvar s = 0; s < `AMC_SLOTS; s++) begin : g_slot
    assign slot_hit[s] = (slot_reg == 2'(s));
  end

  // Request, wait for acceptance, wait for the result
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= ARB_IDLE;
      slot_reg     <= 2'h0;
      conv_req_o   <= 1'b0;
      conv_chan_o  <= AMC_CHAN_TEMP;
      cv.accept    <= 4'h0;
      cv.done      <= 1'b0;
      cv.done_slot <= 2'h0;
      cv.done_data <= `AMC_RESET_BYTE;
    end else begin
      cv.accept <= 4'h0;
      cv.done   <= 1'b0;
      unique case (state_reg)
        ARB_IDLE: begin
          if (|cv.pend) begin
            slot_reg    <= pick;
            conv_req_o  <= 1'b1;
            conv_chan_o <= pick[0] ? AMC_CHAN_CELL : AMC_CHAN_TEMP;
            state_reg   <= ARB_REQ;
          end
        end
        ARB_REQ: begin
          if (conv_ack_i) begin
            conv_req_o <= 1'b0;
            cv.accept  <= slot_hit;
            state_reg  <= ARB_BUSY;
          end
        end
        ARB_BUSY: begin
          if (conv_done_i) begin
            cv.done      <= 1'b1;
            cv.done_slot <= slot_reg;
            cv.done_data <= conv_data_i;
            state_reg    <= ARB_IDLE;
          end
        end
        default: state_reg <= ARB_IDLE;
      endcase
    end
  end
endmodule : amc_conv_arbiter

// ==== logic/amc_measure_ctrl.sv ====
// Temperature and cell measurement control with result registers
`timescale 1ns/100ps
`include "amc_consts.svh"
module amc_measure_ctrl #(
  parameter int unsigned SEC_CYCLES = `AMC_CLK_HZ
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  amc_pkg::amc_mode_t     mode_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  output logic                   conv_req_o,
  output amc_pkg::amc_chan_t     conv_chan_o,
  input  wire logic              conv_ack_i,
  input  wire logic              conv_done_i,
  input  wire logic [7:0]        conv_data_i,
  input  wire logic              supply_event_i,
  input  wire logic [7:0]        supply_data_i,
  output logic                   temp_irq_o,
  output logic                   pm_irq_o
);
  import amc_pkg::*;

  amc_conv_if cv ();

  // Software-visible state
  logic [1:0] start_reg;
  logic [1:0] start_next;
  logic [1:0] temp_period_reg;
  logic [1:0] cell_period_reg;
  logic [2:0] delta_reg;
  logic [7:0] threshold_reg;
  logic       low_cell_flag_reg;
  logic       low_cell_flag_next;
  logic       low_cell_irq_en_reg;
  logic [7:0] temp_result_reg;
  logic [7:0] cell_result_reg;
  logic [7:0] supply_result_reg;
  logic       temp_bg_pend_reg;
  logic       cell_bg_pend_reg;

  // Decoded strobes
  logic wr_start;
  logic wr_interval;
  logic wr_delta;
  logic wr_threshold;
  logic wr_flags;
  logic wr_irq_en;

  // Mode gating
  logic single_ok;
  logic temp_bg_ok;
  logic cell_bg_ok;
  logic temp_due;
  logic cell_due;
  logic temp_bg_keep;
  logic cell_bg_keep;

  // Completion decode
  logic       done_temp;
  logic       done_cell;
  logic       done_single;
  logic [7:0] temp_change_delta;
  logic       temp_moved;
  logic       temp_fire;
  logic       cell_low;
  logic       cell_fire;
  logic [7:0] rd_mux;

  // Read address hits
  logic       rd_temp_res;
  logic       rd_cell_res;
  logic       rd_supply_res;
  logic       rd_start;
  logic       rd_interval;
  logic       rd_delta;
  logic       rd_threshold;
  logic       rd_flags;
  logic       rd_irq_en;

  // Register images as software reads them
  logic [7:0] start_view;
  logic [7:0] interval_view;
  logic [7:0] delta_view;
  logic [7:0] flags_view;
  logic [7:0] irq_en_view;

  // Register port decode
  assign wr_start     = reg_wr_i && (reg_addr_i == `AMC_ADDR_START);
  assign wr_interval  = reg_wr_i && (reg_addr_i == `AMC_ADDR_INTERVAL);
  assign wr_delta     = reg_wr_i && (reg_addr_i == `AMC_ADDR_DELTA);
  assign wr_threshold = reg_wr_i && (reg_addr_i == `AMC_ADDR_THRESHOLD);
  assign wr_flags     = reg_wr_i && (reg_addr_i == `AMC_ADDR_PM_FLAGS);
  assign wr_irq_en    = reg_wr_i && (reg_addr_i == `AMC_ADDR_PM_IRQ_EN);

  // Which conversions each power mode allows
  assign single_ok  = (mode_i == AMC_MAINS_ACTIVE_MODE) ||
                      (mode_i == AMC_CELL_ACTIVE_MODE);
  assign temp_bg_ok = (mode_i == AMC_MAINS_ACTIVE_MODE) ||
                      (mode_i == AMC_CORE_OFF_MODE);
  assign cell_bg_ok = (mode_i == AMC_MAINS_ACTIVE_MODE);

  // Background pending: a tick while one waits merges into it; a mode that
  // forbids the channel drops it, so no stale tick runs in the wrong mode
  assign temp_bg_keep = temp_bg_ok &&
    (temp_due || (temp_bg_pend_reg && !cv.accept[`AMC_SLOT_TEMP_BG]));
  assign cell_bg_keep = cell_bg_ok &&
    (cell_due || (cell_bg_pend_reg && !cv.accept[`AMC_SLOT_CELL_BG]));

  // Slot requests toward the arbiter; single starts wait while the mode forbids them
  assign cv.pend[`AMC_SLOT_TEMP_SINGLE] = start_reg[`AMC_START_TEMP_BIT] && single_ok;
  assign cv.pend[`AMC_SLOT_CELL_SINGLE] = start_reg[`AMC_START_BATT_BIT] && single_ok;
  assign cv.pend[`AMC_SLOT_TEMP_BG]     = temp_bg_pend_reg && temp_bg_ok;
  assign cv.pend[`AMC_SLOT_CELL_BG]     = cell_bg_pend_reg && cell_bg_ok;

  // Start bits: a write sets them, acceptance clears them, a new set wins
  assign start_next[`AMC_START_TEMP_BIT] =
    (wr_start && reg_wdata_i[`AMC_START_TEMP_BIT]) ||
    (start_reg[`AMC_START_TEMP_BIT] && !cv.accept[`AMC_SLOT_TEMP_SINGLE]);
  assign start_next[`AMC_START_BATT_BIT] =
    (wr_start && reg_wdata_i[`AMC_START_BATT_BIT]) ||
    (start_reg[`AMC_START_BATT_BIT] && !cv.accept[`AMC_SLOT_CELL_SINGLE]);

  // Background interval timers, both off while their period field is zero
  amc_interval_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .P1_MIN     (`AMC_TEMP_P1_MIN),
    .P2_MIN     (`AMC_TEMP_P2_MIN),
    .P3_MIN     (`AMC_TEMP_P3_MIN)
  ) u_temp_timer (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .period_i (temp_period_reg),
    .run_i    (temp_bg_ok),
    .due_o    (temp_due)
  );

  amc_interval_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .P1_MIN     (`AMC_CELL_P1_MIN),
    .P2_MIN     (`AMC_CELL_P2_MIN),
    .P3_MIN     (`AMC_CELL_P3_MIN)
  ) u_cell_timer (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .period_i (cell_period_reg),
    .run_i    (cell_bg_ok),
    .due_o    (cell_due)
  );

  // One converter shared by both channels
  amc_conv_arbiter u_arbiter (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .cv          (cv.arb),
    .conv_req_o  (conv_req_o),
    .conv_chan_o (conv_chan_o),
    .conv_ack_i  (conv_ack_i),
    .conv_done_i (conv_done_i),
    .conv_data_i (conv_data_i)
  );

  // Completion decode: slot bit 0 is the channel, slot bit 1 marks background
  assign done_temp   = cv.done && !cv.done_slot[0];
  assign done_cell   = cv.done && cv.done_slot[0];
  assign done_single = !cv.done_slot[1];

  // Change since the last value that interrupted, held in the result register
  assign temp_change_delta  = (cv.done_data > temp_result_reg) ? (cv.done_data - temp_result_reg)
                                                       : (temp_result_reg - cv.done_data);
  assign temp_moved = (delta_reg == `AMC_DELTA_EVERY) ||
                      ((delta_reg != `AMC_DELTA_NONE) &&
                       (temp_change_delta > {5'h0, delta_reg}));
  assign temp_fire  = done_temp && (done_single || temp_moved);

  // Cell: below threshold, or the end of a software start
  assign cell_low  = cv.done_data < threshold_reg;
  assign cell_fire = done_cell && (done_single || cell_low);

  // Low cell flag: hardware set wins over a software clear in the same cycle
  assign low_cell_flag_next = cell_fire ||
    (low_cell_flag_reg && !(wr_flags && !reg_wdata_i[`AMC_LOW_CELL_BIT]));

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_period_reg     <= `AMC_RESET_PERIOD;
      cell_period_reg     <= `AMC_RESET_PERIOD;
      delta_reg           <= `AMC_RESET_DELTA;
      threshold_reg       <= `AMC_RESET_BYTE;
      low_cell_irq_en_reg <= 1'b0;
    end else begin
      if (wr_interval) begin
        temp_period_reg <= reg_wdata_i[`AMC_TEMP_PERIOD_LSB +: `AMC_PERIOD_W];
        cell_period_reg <= reg_wdata_i[`AMC_CELL_PERIOD_LSB +: `AMC_PERIOD_W];
      end
      if (wr_delta) begin
        delta_reg <= reg_wdata_i[`AMC_DELTA_LSB +: `AMC_DELTA_W];
      end
      if (wr_threshold) begin
        threshold_reg <= reg_wdata_i;
      end
      if (wr_irq_en) begin
        low_cell_irq_en_reg <= reg_wdata_i[`AMC_LOW_CELL_BIT];
      end
    end
  end

  // Start bits and background pending; a due tick while one waits merges into it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_reg        <= 2'h0;
      temp_bg_pend_reg <= 1'b0;
      cell_bg_pend_reg <= 1'b0;
    end else begin
      start_reg        <= start_next;
      temp_bg_pend_reg <= temp_bg_keep;
      cell_bg_pend_reg <= cell_bg_keep;
    end
  end

  // Results load only on their channel event; no status flag for temperature
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_result_reg   <= `AMC_RESET_BYTE;
      cell_result_reg   <= `AMC_RESET_BYTE;
      supply_result_reg <= `AMC_RESET_BYTE;
      low_cell_flag_reg <= 1'b0;
      temp_irq_o        <= 1'b0;
      pm_irq_o          <= 1'b0;
    end else begin
      if (temp_fire) begin
        temp_result_reg <= cv.done_data;
      end
      if (cell_fire) begin
        cell_result_reg <= cv.done_data;
      end
      if (supply_event_i) begin
        supply_result_reg <= supply_data_i;
      end
      low_cell_flag_reg <= low_cell_flag_next;
      temp_irq_o        <= temp_fire;
      pm_irq_o          <= low_cell_flag_next && low_cell_irq_en_reg;
    end
  end

  // Read address decode
  assign rd_temp_res   = (reg_addr_i == `AMC_ADDR_TEMP_RESULT);
  assign rd_cell_res   = (reg_addr_i == `AMC_ADDR_BATT_RESULT);
  assign rd_supply_res = (reg_addr_i == `AMC_ADDR_SUPPLY_RESULT);
  assign rd_start      = (reg_addr_i == `AMC_ADDR_START);
  assign rd_interval   = (reg_addr_i == `AMC_ADDR_INTERVAL);
  assign rd_delta      = (reg_addr_i == `AMC_ADDR_DELTA);
  assign rd_threshold  = (reg_addr_i == `AMC_ADDR_THRESHOLD);
  assign rd_flags      = (reg_addr_i == `AMC_ADDR_PM_FLAGS);
  assign rd_irq_en     = (reg_addr_i == `AMC_ADDR_PM_IRQ_EN);

  // Fields placed at their positions; start and period fields already sit at the bottom
  assign start_view    = 8'(start_reg);
  assign interval_view = 8'({cell_period_reg, temp_period_reg});
  assign delta_view    = 8'(delta_reg) << `AMC_DELTA_LSB;
  assign flags_view    = 8'(low_cell_flag_reg) << `AMC_LOW_CELL_BIT;
  assign irq_en_view   = 8'(low_cell_irq_en_reg) << `AMC_LOW_CELL_BIT;

  // Read selection; unmapped addresses and unused bits read zero
  assign rd_mux =
    rd_temp_res   ? temp_result_reg :
    rd_cell_res   ? cell_result_reg :
    rd_supply_res ? supply_result_reg :
    rd_start      ? start_view :
    rd_interval   ? interval_view :
    rd_delta      ? delta_view :
    rd_threshold  ? threshold_reg :
    rd_flags      ? flags_view :
    rd_irq_en     ? irq_en_view :
                    `AMC_RESET_BYTE;

  // Read data registered one cycle after the read strobe, held until next read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `AMC_RESET_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end
endmodule : amc_measure_ctrl

// ==== verification/amc_measure_ctrl_chk.sv ====
// Port checker for the measure control, bound to its top module
`timescale 1ns/100ps
module amc_measure_ctrl_chk #(
  parameter int unsigned SEC_CYCLES = 2
) (
  input wire logic           clk_i,
  input wire logic           rst_b_i,
  input amc_pkg::amc_mode_t  mode_i,
  input wire logic           reg_wr_i,
  input wire logic           reg_rd_i,
  input wire logic [7:0]     reg_rdata_o,
  input wire logic           conv_req_o,
  input amc_pkg::amc_chan_t  conv_chan_o,
  input wire logic           conv_ack_i,
  input wire logic           conv_done_i,
  input wire logic           temp_irq_o,
  input wire logic           pm_irq_o
);
  import amc_pkg::*;
  logic busy_reg;

  // Converter owned from accept to done; a request then would be a second one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) busy_reg <= 1'b0;
    else if (conv_done_i) busy_reg <= 1'b0;
    else if (conv_req_o && conv_ack_i) busy_reg <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_REQ_HOLD: assert property (conv_req_o && !conv_ack_i |=> conv_req_o)
    else $error("request dropped before accept");
  AST_REQ_DROP: assert property (conv_req_o && conv_ack_i |=> !conv_req_o)
    else $error("request kept after accept");
  AST_CHAN_STEADY: assert property (conv_req_o && $past(conv_req_o) |-> $stable(conv_chan_o))
    else $error("channel changed during request");
  AST_ONE_AT_A_TIME: assert property (busy_reg |-> !conv_req_o)
    else $error("request while converter busy");
  AST_TEMP_IRQ_PULSE: assert property (temp_irq_o |=> !temp_irq_o)
    else $error("temperature interrupt longer than one cycle");
  AST_TEMP_IRQ_CAUSE: assert property (temp_irq_o |->
    $past(conv_done_i, 2) && $past(conv_chan_o, 2) == AMC_CHAN_TEMP)
    else $error("temperature interrupt without temperature result");
  AST_CORE_OFF_NO_CELL: assert property ($rose(conv_req_o) && $stable(mode_i) &&
    mode_i == AMC_CORE_OFF_MODE |-> conv_chan_o == AMC_CHAN_TEMP)
    else $error("cell conversion in core-off mode");
  AST_PM_IRQ_CAUSE: assert property ($rose(pm_irq_o) |->
    $past(conv_done_i, 2) || $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("power interrupt without cause");
  AST_RDATA_HOLD: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without read");

  // Main scenarios reached
  cover property ($rose(temp_irq_o));
  cover property ($rose(pm_irq_o));
  cover property (conv_req_o && conv_ack_i && conv_chan_o == AMC_CHAN_CELL);
  cover property (conv_done_i ##[2:10] conv_req_o);
endmodule : amc_measure_ctrl_chk

bind amc_measure_ctrl amc_measure_ctrl_chk #(.SEC_CYCLES(SEC_CYCLES)) amc_measure_ctrl_chk_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .conv_req_o(conv_req_o),
  .conv_chan_o(conv_chan_o), .conv_ack_i(conv_ack_i), .conv_done_i(conv_done_i),
  .temp_irq_o(temp_irq_o), .pm_irq_o(pm_irq_o));

// ==== verification/amc_conv_model.sv ====
// Behavioural model of the temperature and cell converters
`timescale 1ns/100ps
module amc_conv_model (
  input wire logic          clk_i,
  input wire logic          rst_b_i,
  input wire logic          conv_req_o,
  input amc_pkg::amc_chan_t conv_chan_o,
  input wire logic [7:0]    value_i,
  input wire logic [1:0]    slow_i,
  output logic              conv_ack_i,
  output logic              conv_done_i,
  output logic [7:0]        conv_data_i,
  output logic [1:0]        chan_log_o,
  output int                done_cnt_o
);
  // Accept after 0..3 cycles, answer some cycles later, one job at a time
  initial begin
    conv_ack_i = 1'b0;
    conv_done_i = 1'b0;
    conv_data_i = 8'hA5;
    chan_log_o = 2'h0;
    done_cnt_o = 0;
    forever begin
      @(posedge clk_i);
      if (rst_b_i && conv_req_o) begin
        repeat (slow_i) @(posedge clk_i);
        #1 conv_ack_i = 1'b1;
        @(posedge clk_i);
        chan_log_o = {chan_log_o[0], conv_chan_o};
        #1 conv_ack_i = 1'b0;
        repeat (3 + slow_i) @(posedge clk_i);
        #1 conv_done_i = 1'b1;
        conv_data_i = value_i;
        @(posedge clk_i);
        #1 conv_done_i = 1'b0;
        conv_data_i = ~value_i; // Stale data never looks valid
        done_cnt_o++;
      end
    end
  end
endmodule : amc_conv_model

// ==== verification/amc_measure_ctrl_bench.sv ====
// Self-checking bench of the measure control with converter model
`timescale 1ns/100ps
module amc_measure_ctrl_bench;
  import amc_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, supply_event_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, supply_data_i = 8'h00, reg_rdata_o;
  logic conv_req_o, conv_ack_i, conv_done_i, temp_irq_o, pm_irq_o, rd_seen = 1'b0;
  logic [7:0] conv_data_i, val = 8'h00, t0, seed = 8'h31;
  logic [1:0] slow = 2'h0, chan_log;
  amc_mode_t mode_i = AMC_MAINS_ACTIVE_MODE;
  amc_chan_t conv_chan_o;
  logic [7:0] exp_q[$];
  int done_cnt, irq_cnt = 0, err_total = 0, cmp_count = 0, cyc = 0;
  logic [7:0] addr_list[10] = '{8'hD7, 8'hD8, 8'hDF, 8'hEC, 8'hEF, 8'hF3, 8'hF8, 8'hF9, 8'hFA,
                                8'h10};

  amc_measure_ctrl #(.SEC_CYCLES(2)) amc_measure_ctrl_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o),
    .conv_ack_i(conv_ack_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .supply_event_i(supply_event_i), .supply_data_i(supply_data_i),
    .temp_irq_o(temp_irq_o), .pm_irq_o(pm_irq_o));
  amc_conv_model amc_conv_model_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o),
    .value_i(val), .slow_i(slow), .conv_ack_i(conv_ack_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .chan_log_o(chan_log), .done_cnt_o(done_cnt));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask : wr

  // Read with its expected byte noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1 reg_addr_i = a;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
  endtask : rd

  // Bounded wait for the next converter answer, with random latency
  task automatic wait_done();
    int n, k;
    n = done_cnt;
    k = 0;
    seed = lfsr_next(seed);
    slow = seed[1:0];
    while (done_cnt == n && k < 600) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 600) err_total++;
    repeat (4) @(posedge clk_i);
  endtask : wait_done

  // Monitor: read data is held, so it is taken one edge after the taking edge
  always @(posedge clk_i) begin
    if (rd_seen && exp_q.size() > 0) check(reg_rdata_o, exp_q.pop_front());
    rd_seen <= reg_rd_i;
    if (temp_irq_o === 1'b1) irq_cnt++;
  end

  // Hang guard; the whole run needs under two thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    foreach (addr_list[i]) rd(addr_list[i], 8'h00);
    wr(8'hD7, 8'h55);
    rd(8'hD7, 8'h00);
    seed = lfsr_next(seed);
    @(posedge clk_i);
    #1 supply_event_i = 1'b1;
    supply_data_i = seed;
    @(posedge clk_i);
    #1 supply_event_i = 1'b0;
    rd(8'hEF, seed);
    $display("test reset and supply done");
    t0 = {1'b0, seed[6:0]} + 8'h10;
    val = t0;
    wr(8'hD8, 8'h02);
    wait_done();
    rd(8'hD7, t0);
    rd(8'hD8, 8'h00);
    check(irq_cnt[7:0], 8'h01);
    wr(8'hF3, 8'h10);
    wr(8'hF9, 8'h03);
    val = t0 + 8'h01;
    wait_done();
    rd(8'hD7, t0);
    check(irq_cnt[7:0], 8'h01);
    val = t0 + 8'h03;
    wait_done();
    rd(8'hD7, t0 + 8'h03);
    check(irq_cnt[7:0], 8'h02);
    $display("test temperature done");
    mode_i = AMC_CELL_ACTIVE_MODE;
    repeat (300) @(posedge clk_i);
    check(done_cnt[7:0], 8'h03);
    #1 mode_i = AMC_CORE_OFF_MODE;
    val = t0 + 8'h0B;
    wr(8'hD8, 8'h01);
    wait_done();
    rd(8'hD7, t0 + 8'h0B);
    check({6'h00, chan_log}, 8'h00);
    val = 8'hC0;
    wr(8'hF9, 8'h00);
    mode_i = AMC_MAINS_ACTIVE_MODE;
    wait_done();
    check({6'h00, chan_log}, 8'h01);
    rd(8'hDF, 8'hC0);
    rd(8'hF8, 8'h04);
    wr(8'hEC, 8'h04);
    repeat (3) @(posedge clk_i);
    check({7'h00, pm_irq_o}, 8'h01);
    wr(8'hF8, 8'h00);
    repeat (3) @(posedge clk_i);
    check({7'h00, pm_irq_o}, 8'h00);
    $display("test modes done");
    wr(8'hFA, 8'h80);
    wr(8'hF9, 8'h0C);
    val = 8'h90;
    wait_done();
    rd(8'hDF, 8'hC0);
    rd(8'hF8, 8'h00);
    val = 8'h20;
    wait_done();
    rd(8'hDF, 8'h20);
    rd(8'hF8, 8'h04);
    check({7'h00, pm_irq_o}, 8'h01);
    $display("test background cell done");
    wr(8'hF9, 8'h00);
    wr(8'hF8, 8'h00);
    wr(8'hD8, 8'h03);
    wait_done();
    wait_done();
    check({6'h00, chan_log}, 8'h01);
    check(irq_cnt[7:0], 8'h04);
    rd(8'hD8, 8'h00);
    repeat (4) @(posedge clk_i);
    $display("test priority done");
    wr(8'hF3, 8'h38);
    wr(8'hF9, 8'h02);
    wait_done();
    rd(8'hD7, 8'h20);
    check(irq_cnt[7:0], 8'h05);
    wr(8'hF3, 8'h00);
    val = 8'h7F;
    wait_done();
    rd(8'hD7, 8'h20);
    check(irq_cnt[7:0], 8'h05);
    $display("test delta codes done");
    finish_test();
  end
endmodule : amc_measure_ctrl_bench
